// [verilog/pvf_pkg.sv]
// Shared constants and types of the port group VLAN filter.
`default_nettype none
package pvf_pkg;
	localparam int NUM_PORTS   = 10;
	localparam int NUM_GROUPS  = 64;
	localparam int PORT_IDX_W  = 4;
	localparam int GROUP_IDX_W = 6;
	localparam int LABEL_W     = 16;
	localparam int VID_W       = 12;

	localparam logic [VID_W-1:0] MGMT_VID_RESET = 12'h000;
	localparam logic [VID_W-1:0] MGMT_VID_OPEN  = 12'h000;
	localparam logic [VID_W-1:0] PORT_VID_RESET = 12'h001;

	typedef logic [NUM_PORTS-1:0] pvf_mask_type;
	typedef logic [NUM_GROUPS-1:0][NUM_PORTS-1:0] pvf_matrix_type;

	// Gray sequence: disabled, port based, tag based.
	typedef enum logic [1:0] {
		PVF_MODE_DISABLED = 2'h0,
		PVF_MODE_PORT     = 2'h1,
		PVF_MODE_TAG      = 2'h3
	} pvf_mode_type;

	typedef enum logic [2:0] {
		PVF_OP_NONE   = 3'h0,
		PVF_OP_SET    = 3'h1,
		PVF_OP_ADD    = 3'h2,
		PVF_OP_REMOVE = 3'h3,
		PVF_OP_DELETE = 3'h4
	} pvf_op_type;
endpackage
`default_nettype wire

// [verilog/pvf_tbl_if.sv]
// Interface between the filter core and its group table.
`timescale 1ns/1ps
`default_nettype none
interface pvf_tbl_if;
	import pvf_pkg::*;
	pvf_op_type                  wr_op;
	logic [GROUP_IDX_W-1:0]      wr_idx;
	logic [LABEL_W-1:0]          wr_label;
	logic [VID_W-1:0]            wr_vid;
	pvf_mask_type                wr_ports;
	logic [GROUP_IDX_W-1:0]      rd_idx;
	logic [LABEL_W-1:0]          rd_label;
	logic [VID_W-1:0]            rd_vid;
	pvf_matrix_type              members;
	logic [NUM_GROUPS-1:0]       used;

	modport table_side (
		input  wr_op, wr_idx, wr_label, wr_vid, wr_ports, rd_idx,
		output rd_label, rd_vid, members, used
	);
	modport core_side (
		output wr_op, wr_idx, wr_label, wr_vid, wr_ports, rd_idx,
		input  rd_label, rd_vid, members, used
	);
endinterface
`default_nettype wire

// [verilog/pvf_group_table.sv]
// Group table holding label, VLAN identifier and member ports per group.
`timescale 1ns/1ps
`default_nettype none
module pvf_group_table (
	input  wire logic            clk_sys_in,
	input  wire logic            srst_in,
	pvf_tbl_if.table_side        tbl
);
	import pvf_pkg::*;

	logic [LABEL_W-1:0]    label_mem [NUM_GROUPS];
	logic [VID_W-1:0]      vid_mem   [NUM_GROUPS];
	pvf_matrix_type        members_reg;
	logic [NUM_GROUPS-1:0] used_reg;

	// Labels and identifiers are plain storage; only membership and the used flags are reset.
	always_ff @(posedge clk_sys_in) begin
		if (tbl.wr_op == PVF_OP_SET) begin
			label_mem[tbl.wr_idx] <= tbl.wr_label;
			vid_mem[tbl.wr_idx]   <= tbl.wr_vid;
		end
	end

	// Membership edits; a port may sit in any number of groups.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			members_reg <= '0;
			used_reg    <= '0;
		end else begin
			case (tbl.wr_op)
				PVF_OP_SET: begin
					members_reg[tbl.wr_idx] <= tbl.wr_ports;
					used_reg[tbl.wr_idx]    <= 1'b1;
				end
				PVF_OP_ADD: begin
					members_reg[tbl.wr_idx] <=
						members_reg[tbl.wr_idx] | tbl.wr_ports;
				end
				PVF_OP_REMOVE: begin
					members_reg[tbl.wr_idx] <=
						members_reg[tbl.wr_idx] & ~tbl.wr_ports;
				end
				PVF_OP_DELETE: begin
					members_reg[tbl.wr_idx] <= '0;
					used_reg[tbl.wr_idx]    <= 1'b0;
				end
				default: begin
				end
			endcase
		end
	end

	// Read port is combinational; the core registers what it shows.
	assign tbl.rd_label = label_mem[tbl.rd_idx];
	assign tbl.rd_vid   = vid_mem[tbl.rd_idx];
	assign tbl.members  = members_reg;
	assign tbl.used     = used_reg;
endmodule // pvf_group_table
`default_nettype wire

// [verilog/pvf_filter.sv]
// Port group VLAN filter: egress mask and management access decisions.
// Summary of operation
// - Mode is disabled, port based or tag based; reset selects disabled.
// - Port mode forwards only to ports sharing a group with ingress.
// - Ports in no group form one extra shared group.
// - Port mode ignores any VLAN tag; membership alone decides.
// - A common port may join several groups without bridging them.
// - The table holds up to 64 groups at once.
// - Each group stores label, VLAN identifier, members; ports add/remove.
// - Management identifier resets to 0; nonzero restricts by port id.
`timescale 1ns/1ps
`default_nettype none
module pvf_filter (
	input  wire logic                        clk_sys_in,
	input  wire logic                        srst_in,
	input  wire logic                        mode_wr_in,
	input  wire pvf_pkg::pvf_mode_type       mode_in,
	input  wire logic                        mgmt_vid_wr_in,
	input  wire logic [pvf_pkg::VID_W-1:0]   mgmt_vid_in,
	input  wire logic                        port_vid_wr_in,
	input  wire logic [pvf_pkg::PORT_IDX_W-1:0] port_vid_port_in,
	input  wire logic [pvf_pkg::VID_W-1:0]   port_vid_in,
	input  wire pvf_pkg::pvf_op_type         grp_op_in,
	input  wire logic [pvf_pkg::GROUP_IDX_W-1:0] grp_idx_in,
	input  wire logic [pvf_pkg::LABEL_W-1:0] grp_label_in,
	input  wire logic [pvf_pkg::VID_W-1:0]   grp_vid_in,
	input  wire pvf_pkg::pvf_mask_type       grp_ports_in,
	input  wire logic [pvf_pkg::GROUP_IDX_W-1:0] rd_idx_in,
	input  wire logic                        lookup_valid_in,
	input  wire logic [pvf_pkg::PORT_IDX_W-1:0] lookup_port_in,
	output logic                             fwd_valid_out,
	output pvf_pkg::pvf_mask_type            fwd_mask_out,
	output logic                             mgmt_ok_out,
	output pvf_pkg::pvf_mode_type            mode_out,
	output logic [pvf_pkg::LABEL_W-1:0]      rd_label_out,
	output logic [pvf_pkg::VID_W-1:0]        rd_vid_out,
	output pvf_pkg::pvf_mask_type            rd_members_out,
	output logic                             rd_used_out
);
	import pvf_pkg::*;

	pvf_tbl_if tbl ();

	pvf_mode_type          mode_reg;
	logic [VID_W-1:0]      mgmt_vid_reg;
	logic [VID_W-1:0]      port_vid_reg [NUM_PORTS];
	pvf_mask_type          reach    [NUM_PORTS];
	pvf_mask_type          in_group;
	pvf_mask_type          unassigned;
	pvf_mask_type          self_mask;
	pvf_mask_type          group_mask;
	pvf_mask_type          mask_next;
	logic                  port_ok;
	logic                  mgmt_ok_next;
	logic [VID_W-1:0]      lookup_vid;
	logic                  mode_is_port;
	pvf_mask_type          port_vid_hit;

	// Union of the member sets of every live group that holds port p.
	// Unused groups are skipped, so a deleted group can never leak ports,
	// whatever its member bits still hold.
	function automatic pvf_mask_type reach_of(
		input pvf_matrix_type        m,
		input logic [NUM_GROUPS-1:0] u,
		input int                    p
	);
		pvf_mask_type acc;
		acc = '0;
		for (int g = 0; g < NUM_GROUPS; g++) begin
			if (u[g] && m[g][p]) begin
				acc = acc | m[g];
			end
		end
		return acc;
	endfunction

	// One-hot select of a port index; indices past the last port give
	// no bit at all, which is how refused ports fall out of every mask.
	function automatic pvf_mask_type port_onehot(
		input logic [PORT_IDX_W-1:0] idx
	);
		pvf_mask_type sel;
		sel = '0;
		for (int q = 0; q < NUM_PORTS; q++) begin
			if (idx == PORT_IDX_W'(q)) begin
				sel[q] = 1'b1;
			end
		end
		return sel;
	endfunction

	// Group storage lives in its own module; everything that belongs to
	// the table travels through the interface bundle.
	pvf_group_table u_table (
		.clk_sys_in (clk_sys_in),
		.srst_in    (srst_in),
		.tbl        (tbl.table_side)
	);

	// Table edits pass straight through; the table registers them.
	assign tbl.wr_op    = grp_op_in;
	assign tbl.wr_idx   = grp_idx_in;
	assign tbl.wr_label = grp_label_in;
	assign tbl.wr_vid   = grp_vid_in;
	assign tbl.wr_ports = grp_ports_in;
	assign tbl.rd_idx   = rd_idx_in;

	// Per-port reach; a common port widens each group but never joins
	// two groups to each other, since only groups holding p contribute.
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_reach
		assign reach[p]    = reach_of(tbl.members, tbl.used, p);
		assign in_group[p] = reach[p][p];
	end

	// Ports outside every group share one implicit group.
	// Nothing is stored for it; it is simply the complement of the rest.
	assign unassigned = ~in_group;

	// Lookup decode. The frame's tag is deliberately not an input here:
	// in port based mode membership alone decides, and keeping the tag
	// out means no later change can let it leak into the decision.
	// Ingress numbers past the last port are refused with an empty mask.
	assign port_ok    = lookup_port_in < PORT_IDX_W'(NUM_PORTS);
	assign self_mask  = port_onehot(lookup_port_in);
	assign group_mask = !port_ok ? '0 :
		in_group[lookup_port_in] ? reach[lookup_port_in]
		: unassigned;

	// Only the port based setting filters. Tag based forwarding is decided
	// elsewhere, and the unused code 2 behaves like disabled, so both let
	// every port through; a frame never returns to its own ingress port.
	assign mode_is_port = (mode_reg == PVF_MODE_PORT);
	assign mask_next    = !port_ok ? '0 :
		mode_is_port ? (group_mask & ~self_mask)
		: ~self_mask;

	// Management access: open while the identifier is zero, otherwise
	// only to ingress ports whose untagged identifier matches it.
	assign lookup_vid   = port_ok ? port_vid_reg[lookup_port_in] : '0;
	assign mgmt_ok_next = port_ok && ((mgmt_vid_reg == MGMT_VID_OPEN)
		|| (lookup_vid == mgmt_vid_reg));

	// Operating mode; it comes up disabled so that a switch with an empty
	// table still forwards everywhere until software chooses otherwise.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			mode_reg <= PVF_MODE_DISABLED;
		end else if (mode_wr_in) begin
			mode_reg <= mode_in;
		end
	end

	// Management identifier; zero leaves management open to every port.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			mgmt_vid_reg <= MGMT_VID_RESET;
		end else if (mgmt_vid_wr_in) begin
			mgmt_vid_reg <= mgmt_vid_in;
		end
	end

	// Port write select; an index past the last port selects nothing, so
	// such a write is dropped rather than landing on a wrapped port.
	assign port_vid_hit = port_vid_wr_in ? port_onehot(port_vid_port_in)
		: '0;

	// Untagged port identifiers, one small register per port.
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port_vid
		always_ff @(posedge clk_sys_in) begin
			if (srst_in) begin
				port_vid_reg[p] <= PORT_VID_RESET;
			end else if (port_vid_hit[p]) begin
				port_vid_reg[p] <= port_vid_in;
			end
		end
	end

	// Answer strobe, exactly one cycle after each lookup strobe.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			fwd_valid_out <= 1'b0;
		end else begin
			fwd_valid_out <= lookup_valid_in;
		end
	end

	// Answer data holds between lookups, so a slow consumer may read it
	// late; the price is that it is only fresh while the strobe is high.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			fwd_mask_out <= '0;
			mgmt_ok_out  <= 1'b0;
		end else if (lookup_valid_in) begin
			fwd_mask_out <= mask_next;
			mgmt_ok_out  <= mgmt_ok_next;
		end
	end

	// Mode status, one cycle behind the working setting.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			mode_out <= PVF_MODE_DISABLED;
		end else begin
			mode_out <= mode_reg;
		end
	end

	// Table readback, registered so that the combinational table read
	// never reaches a pin. Label and identifier are not reset, so a group
	// that was never set reads back unknown in those two fields.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			rd_label_out   <= '0;
			rd_vid_out     <= '0;
			rd_members_out <= '0;
			rd_used_out    <= 1'b0;
		end else begin
			rd_label_out   <= tbl.rd_label;
			rd_vid_out     <= tbl.rd_vid;
			rd_members_out <= tbl.members[rd_idx_in];
			rd_used_out    <= tbl.used[rd_idx_in];
		end
	end
endmodule // pvf_filter
`default_nettype wire

// [verification/pvf_station.sv]
// Station model that offers random frames for forwarding lookups.
`timescale 1ns/1ps
`default_nettype none
module pvf_station (
	input  wire logic                            clk_sys_in,
	input  wire logic                            en_in,
	output logic                                 valid_out = 1'b0,
	output logic [pvf_pkg::PORT_IDX_W-1:0]       port_out = '0
);
	// Ports 10 and 11 are offered too, so refused lookups are exercised.
	always @(posedge clk_sys_in) begin
		valid_out <= en_in & 1'($urandom_range(1));
		port_out <= 4'($urandom_range(11));
	end
endmodule // pvf_station
`default_nettype wire

// [verification/pvf_props.sv]
// Timing checker bound to the port group VLAN filter.
`timescale 1ns/1ps
`default_nettype none
module pvf_props (
	input wire logic                            clk_sys_in,
	input wire logic                            srst_in,
	input wire logic                            mode_wr_in,
	input wire pvf_pkg::pvf_mode_type           mode_in,
	input wire pvf_pkg::pvf_op_type             grp_op_in,
	input wire logic [pvf_pkg::GROUP_IDX_W-1:0] grp_idx_in,
	input wire pvf_pkg::pvf_mask_type           grp_ports_in,
	input wire logic [pvf_pkg::GROUP_IDX_W-1:0] rd_idx_in,
	input wire logic                            lookup_valid_in,
	input wire logic [pvf_pkg::PORT_IDX_W-1:0]  lookup_port_in,
	input wire logic                            fwd_valid_out,
	input wire pvf_pkg::pvf_mask_type           fwd_mask_out,
	input wire logic                            mgmt_ok_out,
	input wire pvf_pkg::pvf_mode_type           mode_out,
	input wire pvf_pkg::pvf_mask_type           rd_members_out,
	input wire logic                            rd_used_out
);
	import pvf_pkg::*;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);
	// A group op followed by a quiet cycle reading back the same group.
	sequence s_set_rd;
		grp_op_in == PVF_OP_SET ##1
		rd_idx_in == $past(grp_idx_in) && grp_op_in == PVF_OP_NONE;
	endsequence
	sequence s_del_rd;
		grp_op_in == PVF_OP_DELETE ##1
		rd_idx_in == $past(grp_idx_in) && grp_op_in == PVF_OP_NONE;
	endsequence
	sequence s_mode_wr;
		mode_wr_in ##1 !mode_wr_in [*2];
	endsequence
	a_valid_follows: assert property (
		lookup_valid_in |=> fwd_valid_out) else $error("lookup answer lost");
	a_valid_quiet: assert property (
		!lookup_valid_in |=> !fwd_valid_out) else $error("answer without lookup");
	a_bad_port: assert property (
		lookup_valid_in && lookup_port_in > 4'h9
		|=> fwd_mask_out == '0 && !mgmt_ok_out) else $error("bad port passed");
	a_own_excluded: assert property (
		lookup_valid_in && lookup_port_in < 4'hA
		|=> !fwd_mask_out[$past(lookup_port_in)]) else $error("ingress echoed");
	a_mask_holds: assert property (
		!lookup_valid_in |=> $stable(fwd_mask_out) && $stable(mgmt_ok_out))
		else $error("answer moved while idle");
	a_reset_clears: assert property (
		$fell(srst_in) |-> fwd_mask_out == '0 && mode_out == PVF_MODE_DISABLED)
		else $error("reset state wrong");
	a_mode_settles: assert property (
		s_mode_wr |-> mode_out == $past(mode_in, 2)) else $error("mode not taken");
	a_set_readback: assert property (
		s_set_rd |=> rd_used_out && rd_members_out == $past(grp_ports_in, 2))
		else $error("set group misread");
	a_delete_clears: assert property (
		s_del_rd |=> !rd_used_out && rd_members_out == '0)
		else $error("deleted group still present");
endmodule // pvf_props
bind pvf_filter pvf_props i_props (.clk_sys_in, .srst_in, .mode_wr_in,
	.mode_in, .grp_op_in, .grp_idx_in, .grp_ports_in, .rd_idx_in,
	.lookup_valid_in, .lookup_port_in, .fwd_valid_out, .fwd_mask_out,
	.mgmt_ok_out, .mode_out, .rd_members_out, .rd_used_out);
`default_nettype wire

// [verification/pvf_filter_bench.sv]
// Self-checking bench of the port group VLAN filter.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; \
	if ((a) !== (b)) begin mismatches++; \
	$display("FAIL %0t value differs", $time); end end
module pvf_filter_bench;
	import pvf_pkg::*;
	logic clk_sys_in = 1'b0, srst_in = 1'b1, mode_wr_in = 1'b0;
	logic mgmt_vid_wr_in = 1'b0, port_vid_wr_in = 1'b0, tb_valid = 1'b0;
	logic st_en = 1'b0, st_valid, fwd_valid_out, mgmt_ok_out, rd_used_out;
	pvf_mode_type mode_in = PVF_MODE_DISABLED, mode_out, sh_mode;
	pvf_op_type grp_op_in = PVF_OP_NONE;
	logic [VID_W-1:0] mgmt_vid_in = '0, port_vid_in = '0, grp_vid_in = '0;
	logic [VID_W-1:0] rd_vid_out, sh_mvid, sh_untagged_port_vlan_id [NUM_PORTS];
	logic [PORT_IDX_W-1:0] port_vid_port_in = '0, tb_port = '0, st_port, lp;
	logic [GROUP_IDX_W-1:0] grp_idx_in = '0, rd_idx_in = '0;
	logic [LABEL_W-1:0] grp_label_in = '0, rd_label_out;
	pvf_mask_type grp_ports_in = '0, fwd_mask_out, rd_members_out;
	pvf_mask_type sh_mem [NUM_GROUPS];
	logic sh_used [NUM_GROUPS];
	logic [LABEL_W-1:0] sh_lab [NUM_GROUPS];
	logic [VID_W-1:0] sh_gvid [NUM_GROUPS];
	logic sh_set [NUM_GROUPS] = '{default: 1'b0};
	int mismatches = 0, samples_checked = 0, cyc = 0;
	wire logic lookup_valid_in = tb_valid | st_valid;
	wire logic [PORT_IDX_W-1:0] lookup_port_in = st_valid ? st_port : tb_port;
	pvf_filter i_dut (.clk_sys_in, .srst_in, .mode_wr_in, .mode_in,
		.mgmt_vid_wr_in, .mgmt_vid_in, .port_vid_wr_in, .port_vid_port_in,
		.port_vid_in, .grp_op_in, .grp_idx_in, .grp_label_in, .grp_vid_in,
		.grp_ports_in, .rd_idx_in, .lookup_valid_in, .lookup_port_in,
		.fwd_valid_out, .fwd_mask_out, .mgmt_ok_out, .mode_out,
		.rd_label_out, .rd_vid_out, .rd_members_out, .rd_used_out);
	pvf_station i_station (.clk_sys_in, .en_in(st_en),
		.valid_out(st_valid), .port_out(st_port));
	always #2.5 clk_sys_in = ~clk_sys_in;
	// Expected egress set; the tag is no input, so membership decides.
	function automatic pvf_mask_type exp_mask(input int p);
		pvf_mask_type r = '1;
		logic hit = 1'b0;
		if (p > 9) return '0;
		if (sh_mode == PVF_MODE_PORT) begin
			r = '0;
			for (int g = 0; g < NUM_GROUPS; g++) if (sh_used[g] && sh_mem[g][p]) begin
				r |= sh_mem[g];
				hit = 1'b1;
			end
			if (!hit) begin
				r = '1;
				for (int g = 0; g < NUM_GROUPS; g++) if (sh_used[g]) r &= ~sh_mem[g];
			end
		end
		r[p] = 1'b0;
		return r;
	endfunction
	task finish_test();
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Answers are judged one edge after the lookup was taken.
	// A hang is cut at a ceiling well above the planned run length.
	always @(posedge clk_sys_in) begin
		cyc++;
		if (!srst_in && fwd_valid_out === 1'b1) begin
			`CHK(fwd_mask_out, exp_mask(lp))
			`CHK(mgmt_ok_out, lp < 10 && (sh_mvid == 0 || sh_untagged_port_vlan_id[lp] == sh_mvid))
		end
		lp = lookup_port_in;
		if (cyc == 20000) begin
			mismatches++;
			finish_test();
		end
	end
	task sh_reset();
		sh_mode = PVF_MODE_DISABLED;
		sh_mvid = MGMT_VID_RESET;
		foreach (sh_untagged_port_vlan_id[i]) sh_untagged_port_vlan_id[i] = PORT_VID_RESET;
		foreach (sh_used[i]) sh_used[i] = 1'b0;
		foreach (sh_mem[i]) sh_mem[i] = '0;
	endtask
	task sweep();
		for (int p = 0; p < 12; p++) begin
			@(posedge clk_sys_in);
			tb_valid <= 1'b1;
			tb_port <= 4'(p);
			@(posedge clk_sys_in);
			tb_valid <= 1'b0;
			@(posedge clk_sys_in);
		end
	endtask
	task set_mode(input pvf_mode_type m);
		@(posedge clk_sys_in);
		mode_wr_in <= 1'b1;
		mode_in <= m;
		@(posedge clk_sys_in);
		mode_wr_in <= 1'b0;
		sh_mode = m;
		repeat (2) @(posedge clk_sys_in);
		#1 `CHK(mode_out, m)
	endtask
	// One write of the management id or of a port's untagged id.
	task set_vid(input logic mg, input int p, input int v);
		@(posedge clk_sys_in);
		mgmt_vid_wr_in <= mg;
		port_vid_wr_in <= !mg;
		port_vid_port_in <= 4'(p);
		mgmt_vid_in <= 12'(v);
		port_vid_in <= 12'(v);
		@(posedge clk_sys_in);
		mgmt_vid_wr_in <= 1'b0;
		port_vid_wr_in <= 1'b0;
		if (mg) sh_mvid = 12'(v);
		else if (p < 10) sh_untagged_port_vlan_id[p] = 12'(v);
	endtask
	// Group op with read-back of the same group two edges later.
	task grp(input pvf_op_type op, input int g, input pvf_mask_type pm);
		@(posedge clk_sys_in);
		grp_op_in <= op;
		grp_idx_in <= 6'(g);
		rd_idx_in <= 6'(g);
		grp_ports_in <= pm;
		grp_label_in <= 16'($urandom);
		grp_vid_in <= 12'($urandom);
		@(posedge clk_sys_in);
		grp_op_in <= PVF_OP_NONE;
		if (op == PVF_OP_SET) begin
			sh_lab[g] = grp_label_in;
			sh_gvid[g] = grp_vid_in;
			sh_set[g] = 1'b1;
		end
		if (op == PVF_OP_SET) sh_mem[g] = pm;
		if (op == PVF_OP_ADD) sh_mem[g] |= pm;
		if (op == PVF_OP_REMOVE) sh_mem[g] &= ~pm;
		if (op == PVF_OP_DELETE) sh_mem[g] = '0;
		sh_used[g] = (op == PVF_OP_SET) | (sh_used[g] & op != PVF_OP_DELETE);
		@(posedge clk_sys_in);
		#1 `CHK(rd_members_out, sh_mem[g])
		`CHK(rd_used_out, sh_used[g])
		if (sh_set[g]) begin
			`CHK(rd_label_out, sh_lab[g])
			`CHK(rd_vid_out, sh_gvid[g])
		end
	endtask
	initial begin
		void'($urandom(32'h0bf5));
		sh_reset();
		repeat (16) @(posedge clk_sys_in);
		srst_in <= 1'b0;
		sweep();
		set_mode(PVF_MODE_PORT);
		sweep();
		grp(PVF_OP_SET, 0, 10'h203);
		grp(PVF_OP_SET, 63, 10'h20C);
		sweep();
		grp(PVF_OP_ADD, 0, 10'h010);
		grp(PVF_OP_REMOVE, 0, 10'h002);
		grp(PVF_OP_DELETE, 63, 10'h3FF);
		set_vid(1'b0, 3, 5);
		set_vid(1'b0, 12, 5);
		set_vid(1'b1, 0, 5);
		sweep();
		repeat (24) grp(pvf_op_type'(1 + $urandom_range(3)),
			$urandom_range(63), 10'($urandom));
		// Random station traffic in tag mode and then in port mode.
		for (int i = 0; i < 2; i++) begin
			set_mode(i ? PVF_MODE_PORT : PVF_MODE_TAG);
			st_en <= 1'b1;
			repeat (300) @(posedge clk_sys_in);
			st_en <= 1'b0;
			repeat (3) @(posedge clk_sys_in);
		end
		srst_in <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		sh_reset();
		srst_in <= 1'b0;
		sweep();
		// Let the last answer be judged before the verdict.
		repeat (2) @(posedge clk_sys_in);
		finish_test();
	end
endmodule // pvf_filter_bench
`default_nettype wire
